// ---- verilog/pllsr_cfg.svh ----
// register offsets, field positions and reset values of the pll status
// and first output driver control slice
// assumes: included by its bare name from the package and the design files
`ifndef PLLSR_CFG_SVH
`define PLLSR_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PLLSR_ADDR_W 10
`define PLLSR_OFS_REF_MONITOR_CFG 10'h01A
`define PLLSR_OFS_READBACK_STATUS 10'h01F
`define PLLSR_OFS_OUTPUT0_CTRL 10'h0F0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLLSR_RST_REF_MONITOR_CFG 8'h00
`define PLLSR_RST_OUTPUT0_CTRL 8'h64

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLLSR_MON_THRESH_SEL_BIT 6
`define PLLSR_OUT_FORMAT_BIT 7
`define PLLSR_OUT_LEG_B_BIT 6
`define PLLSR_OUT_LEG_A_BIT 5
`define PLLSR_OUT_POL_HI_BIT 4
`define PLLSR_OUT_POL_LO_BIT 3
`define PLLSR_OUT_SWING_HI_BIT 2
`define PLLSR_OUT_SWING_LO_BIT 1
`define PLLSR_OUT_PDOWN_BIT 0

`endif

// ---- verilog/pllsr_pkg.sv ----
// types shared by the pll status and output format register slice
// assumes: pllsr_cfg.svh is on the include path
`include "pllsr_cfg.svh"

package pllsr_pkg;

    // live monitor inputs, in readback bit order
    typedef struct packed {
        logic osc_cal_done;
        logic holdover_active;
        logic second_ref_selected;
        logic osc_above_thresh;
        logic second_ref_above_thresh;
        logic first_ref_above_thresh;
        logic pll_locked;
    } pllsr_status_t;

    // decoded drive of the first clock output
    typedef struct packed {
        logic pecl_enable;
        logic pecl_power_down;
        logic [1:0] pecl_swing;
        logic pecl_invert;
        logic leg_a_enable;
        logic leg_b_enable;
        logic leg_a_invert;
        logic leg_b_invert;
    } pllsr_drive_t;

endpackage

// ---- verilog/pllsr_sync.sv ----
// two flip-flop synchroniser for a bundle of independent levels
// assumes: each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ps
`default_nettype none

module pllsr_sync #(
    parameter int WIDTH = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

// ---- verilog/pllsr_regs.sv ----
// pll readback status and first clock output driver control registers
// assumes: the serial control port turns frames into single-cycle register
// strobes on CLK; monitor inputs arrive from other clock domains
//
// What this block does
// R1 - status bit 4 reads 1 when second reference feeds pll, else 0
// R2 - status bit 3 reads 1 when oscillator frequency exceeds its threshold
// R3 - status bit 2 reads second reference above threshold chosen by 0x01A[6]
// R4 - status bit 1 reads first reference above that same threshold
// R5 - status bit 0 reads 1 while the pll is locked
// R6 - control bit 7 picks driver: 0 lvpecl (default), 1 two cmos legs
// R7 - bits 6:5 enable cmos legs only in cmos mode; default both on
// R8 - bits 4:3 set polarity; lvpecl ignores bit 4, bit 3 swaps legs
// R9 - cmos with bits 4:3 both zero drives both legs noninverting
// R10 - control bit 0 puts the lvpecl driver into safe power-down
// R11 - writes to status byte do nothing; reads return live monitor values
`timescale 1ns/1ps
`default_nettype none
`include "pllsr_cfg.svh"

module pllsr_regs (
    input wire logic CLK,
    input wire logic RST,
    // register strobes from the serial control port
    input wire logic [`PLLSR_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // monitor levels from pll, reference and oscillator logic
    input wire logic SECOND_REF_SELECTED,
    input wire logic OSC_ABOVE_THRESH,
    input wire logic SECOND_REF_ABOVE_THRESH,
    input wire logic FIRST_REF_ABOVE_THRESH,
    input wire logic PLL_LOCKED,
    input wire logic OSC_CAL_DONE,
    input wire logic HOLDOVER_ACTIVE,
    // threshold choice for the reference frequency monitors
    output logic REF_THRESH_SEL,
    // first clock output drive
    output logic FIRST_OUT_PECL_ENABLE,
    output logic FIRST_OUT_PECL_POWER_DOWN,
    output logic [1:0] FIRST_OUT_PECL_SWING,
    output logic FIRST_OUT_PECL_INVERT,
    output logic FIRST_OUT_LEG_A_ENABLE,
    output logic FIRST_OUT_LEG_B_ENABLE,
    output logic FIRST_OUT_LEG_A_INVERT,
    output logic FIRST_OUT_LEG_B_INVERT
);

    // ----------------------------------------------------------------
    // monitor input synchronisation
    // ----------------------------------------------------------------
    pllsr_pkg::pllsr_status_t status_raw;
    pllsr_pkg::pllsr_status_t status_live;

    always_comb begin
        status_raw.osc_cal_done = OSC_CAL_DONE;
        status_raw.holdover_active = HOLDOVER_ACTIVE;
        status_raw.second_ref_selected = SECOND_REF_SELECTED;
        status_raw.osc_above_thresh = OSC_ABOVE_THRESH;
        status_raw.second_ref_above_thresh = SECOND_REF_ABOVE_THRESH;
        status_raw.first_ref_above_thresh = FIRST_REF_ABOVE_THRESH;
        status_raw.pll_locked = PLL_LOCKED;
    end

    pllsr_sync #(
        .WIDTH($bits(pllsr_pkg::pllsr_status_t))
    ) u_status_sync (
        .clk(CLK),
        .rst(RST),
        .async_in(status_raw),
        .sync_out(status_live)
    );

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    logic [7:0] ref_monitor_cfg;
    logic [7:0] output0_driver_control;
    logic [7:0] next_ref_monitor_cfg;
    logic [7:0] next_output0_driver_control;

    always_comb begin
        next_ref_monitor_cfg = ref_monitor_cfg;
        next_output0_driver_control = output0_driver_control;
        if (REG_WR) begin
            unique case (REG_ADDR)
                `PLLSR_OFS_REF_MONITOR_CFG: begin
                    next_ref_monitor_cfg = REG_WDATA;
                end
                `PLLSR_OFS_OUTPUT0_CTRL: begin
                    next_output0_driver_control = REG_WDATA;
                end
                // status byte and unmapped offsets absorb writes [R11]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ref_monitor_cfg <= `PLLSR_RST_REF_MONITOR_CFG;
            output0_driver_control <= `PLLSR_RST_OUTPUT0_CTRL;
        end else begin
            ref_monitor_cfg <= next_ref_monitor_cfg;
            output0_driver_control <= next_output0_driver_control;
        end
    end

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    function automatic logic [7:0] status_byte(input pllsr_pkg::pllsr_status_t s);
        logic [7:0] b;
        b = 8'h00;
        b[6] = s.osc_cal_done;
        b[5] = s.holdover_active;
        b[4] = s.second_ref_selected; // [R1]
        b[3] = s.osc_above_thresh; // [R2]
        b[2] = s.second_ref_above_thresh; // [R3]
        b[1] = s.first_ref_above_thresh; // [R4]
        b[0] = s.pll_locked; // [R5]
        return b;
    endfunction

    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [7:0] rdata;
    logic rvalid;

    always_comb begin
        next_rdata = 8'h00;
        next_rvalid = REG_RD;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `PLLSR_OFS_REF_MONITOR_CFG: begin
                    next_rdata = ref_monitor_cfg;
                end
                `PLLSR_OFS_READBACK_STATUS: begin
                    next_rdata = status_byte(status_live); // [R11]
                end
                `PLLSR_OFS_OUTPUT0_CTRL: begin
                    next_rdata = output0_driver_control;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign REG_RDATA = rdata;
    assign REG_RVALID = rvalid;

    // ----------------------------------------------------------------
    // output driver decode
    // ----------------------------------------------------------------
    pllsr_pkg::pllsr_drive_t next_drive;
    pllsr_pkg::pllsr_drive_t drive;
    logic cmos_mode;
    logic pol_hi;
    logic pol_lo;

    always_comb begin
        cmos_mode = output0_driver_control[`PLLSR_OUT_FORMAT_BIT]; // [R6]
        pol_hi = output0_driver_control[`PLLSR_OUT_POL_HI_BIT];
        pol_lo = output0_driver_control[`PLLSR_OUT_POL_LO_BIT];
        next_drive.pecl_enable = !cmos_mode; // [R6]
        next_drive.pecl_power_down = output0_driver_control[`PLLSR_OUT_PDOWN_BIT]; // [R10]
        next_drive.pecl_swing =
            output0_driver_control[`PLLSR_OUT_SWING_HI_BIT:`PLLSR_OUT_SWING_LO_BIT];
        // lvpecl: bit 4 ignored, bit 3 swaps true and complement [R8]
        next_drive.pecl_invert = pol_lo;
        // legs only driven in cmos mode, otherwise tristate [R7]
        next_drive.leg_a_enable = cmos_mode && output0_driver_control[`PLLSR_OUT_LEG_A_BIT];
        next_drive.leg_b_enable = cmos_mode && output0_driver_control[`PLLSR_OUT_LEG_B_BIT];
        // cmos: 00 n/n, 01 i/i, 10 n/i, 11 i/n [R8] [R9]
        if (cmos_mode) begin
            next_drive.leg_a_invert = pol_lo;
            next_drive.leg_b_invert = pol_hi ^ pol_lo;
        end else begin
            next_drive.leg_a_invert = pol_lo;
            next_drive.leg_b_invert = !pol_lo;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            // matches decode of the control reset value
            drive.pecl_enable <= 1'b1;
            drive.pecl_power_down <= 1'b0;
            drive.pecl_swing <= 2'h2;
            drive.pecl_invert <= 1'b0;
            drive.leg_a_enable <= 1'b0;
            drive.leg_b_enable <= 1'b0;
            drive.leg_a_invert <= 1'b0;
            drive.leg_b_invert <= 1'b1;
        end else begin
            drive <= next_drive;
        end
    end

    logic next_thresh_sel;
    logic thresh_sel;

    always_comb begin
        next_thresh_sel = ref_monitor_cfg[`PLLSR_MON_THRESH_SEL_BIT]; // [R3] [R4]
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            thresh_sel <= 1'b0;
        end else begin
            thresh_sel <= next_thresh_sel;
        end
    end

    assign REF_THRESH_SEL = thresh_sel;
    assign FIRST_OUT_PECL_ENABLE = drive.pecl_enable;
    assign FIRST_OUT_PECL_POWER_DOWN = drive.pecl_power_down;
    assign FIRST_OUT_PECL_SWING = drive.pecl_swing;
    assign FIRST_OUT_PECL_INVERT = drive.pecl_invert;
    assign FIRST_OUT_LEG_A_ENABLE = drive.leg_a_enable;
    assign FIRST_OUT_LEG_B_ENABLE = drive.leg_b_enable;
    assign FIRST_OUT_LEG_A_INVERT = drive.leg_a_invert;
    assign FIRST_OUT_LEG_B_INVERT = drive.leg_b_invert;

endmodule

`default_nettype wire

// ---- bench/pllsr_regs_chk.sv ----
// assertions on the pll status and first output control register slice
// assumes: bound to pllsr_regs; one clock CLK, synchronous active high RST
`timescale 1ns/1ps
`default_nettype none
`include "pllsr_cfg.svh"

module pllsr_regs_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [`PLLSR_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic SECOND_REF_SELECTED,
    input wire logic OSC_ABOVE_THRESH,
    input wire logic SECOND_REF_ABOVE_THRESH,
    input wire logic FIRST_REF_ABOVE_THRESH,
    input wire logic PLL_LOCKED,
    input wire logic OSC_CAL_DONE,
    input wire logic HOLDOVER_ACTIVE,
    input wire logic REF_THRESH_SEL,
    input wire logic FIRST_OUT_PECL_ENABLE,
    input wire logic FIRST_OUT_PECL_POWER_DOWN,
    input wire logic FIRST_OUT_PECL_INVERT,
    input wire logic FIRST_OUT_LEG_A_ENABLE,
    input wire logic FIRST_OUT_LEG_B_ENABLE,
    input wire logic FIRST_OUT_LEG_A_INVERT,
    input wire logic FIRST_OUT_LEG_B_INVERT
);
    // ----------------------------------------------------------------
    // helpers: edges since reset, write data two cycles back
    // ----------------------------------------------------------------
    wire logic [6:0] mon = {OSC_CAL_DONE, HOLDOVER_ACTIVE, SECOND_REF_SELECTED,
        OSC_ABOVE_THRESH, SECOND_REF_ABOVE_THRESH, FIRST_REF_ABOVE_THRESH, PLL_LOCKED};
    logic [1:0] rst_age;
    logic [1:0] next_rst_age;
    logic [7:0] wd1;
    logic [7:0] wd2;
    logic [7:0] next_wd1;
    logic [7:0] next_wd2;
    always_comb begin
        next_rst_age = (rst_age == 2'h3) ? rst_age : rst_age + 2'h1;
        if (RST) begin
            next_rst_age = 2'h0;
        end
        next_wd1 = REG_WDATA;
        next_wd2 = wd1;
    end
    always_ff @(posedge CLK) begin
        rst_age <= next_rst_age;
        wd1 <= next_wd1;
        wd2 <= next_wd2;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_wr(a);
        REG_WR && REG_ADDR == a ##2 1'b1;
    endsequence
    sequence s_stat_rd;
        REG_RD && REG_ADDR == `PLLSR_OFS_READBACK_STATUS && rst_age >= 2'h2 ##1 1'b1;
    endsequence
    property p_status;
        s_stat_rd |-> REG_RDATA == {1'b0, $past(mon, 3)};
    endproperty

    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read strobe not answered next cycle");
    a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("read answer without read strobe");
    a_rdata_idle: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
        else $error("read data not zero while idle");
    a_status_live: assert property (p_status)
        else $error("status readback differs from monitor levels");
    a_thresh_sel: assert property (s_wr(`PLLSR_OFS_REF_MONITOR_CFG) |->
        REF_THRESH_SEL == wd2[6]) else $error("threshold select wrong");
    a_format_sel: assert property (s_wr(`PLLSR_OFS_OUTPUT0_CTRL) |->
        FIRST_OUT_PECL_ENABLE == !wd2[7]) else $error("driver format wrong");
    a_leg_enable: assert property (s_wr(`PLLSR_OFS_OUTPUT0_CTRL) |->
        {FIRST_OUT_LEG_B_ENABLE, FIRST_OUT_LEG_A_ENABLE} == (wd2[6:5] & {2{wd2[7]}}))
        else $error("cmos leg enables wrong");
    a_leg_polarity: assert property (s_wr(`PLLSR_OFS_OUTPUT0_CTRL) |->
        FIRST_OUT_LEG_A_INVERT == wd2[3] && FIRST_OUT_PECL_INVERT == wd2[3] &&
        FIRST_OUT_LEG_B_INVERT == (wd2[7] ? wd2[4] ^ wd2[3] : !wd2[3]))
        else $error("output polarity wrong");
    a_power_down: assert property (s_wr(`PLLSR_OFS_OUTPUT0_CTRL) |->
        FIRST_OUT_PECL_POWER_DOWN == wd2[0]) else $error("power-down wrong");
endmodule

bind pllsr_regs pllsr_regs_chk u_chk (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
    .REG_RDATA, .REG_RVALID, .SECOND_REF_SELECTED, .OSC_ABOVE_THRESH,
    .SECOND_REF_ABOVE_THRESH, .FIRST_REF_ABOVE_THRESH, .PLL_LOCKED, .OSC_CAL_DONE,
    .HOLDOVER_ACTIVE, .REF_THRESH_SEL, .FIRST_OUT_PECL_ENABLE, .FIRST_OUT_PECL_POWER_DOWN,
    .FIRST_OUT_PECL_INVERT, .FIRST_OUT_LEG_A_ENABLE, .FIRST_OUT_LEG_B_ENABLE,
    .FIRST_OUT_LEG_A_INVERT, .FIRST_OUT_LEG_B_INVERT);
`default_nettype wire

// ---- bench/pllsr_regs_tb_top.sv ----
// self-checking bench for the pll status and output control registers
// assumes: design, package and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "pllsr_cfg.svh"

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module pllsr_regs_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [`PLLSR_ADDR_W-1:0] addr = 10'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [6:0] mon = 7'h00;
    logic [7:0] d;
    wire logic [7:0] rdata;
    wire logic rvalid;
    wire logic thr_sel;
    wire pllsr_pkg::pllsr_drive_t drv;
    int err_total = 0;
    int tests_run = 0;

    pllsr_regs uut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SECOND_REF_SELECTED(mon[4]),
        .OSC_ABOVE_THRESH(mon[3]), .SECOND_REF_ABOVE_THRESH(mon[2]),
        .FIRST_REF_ABOVE_THRESH(mon[1]), .PLL_LOCKED(mon[0]), .OSC_CAL_DONE(mon[6]),
        .HOLDOVER_ACTIVE(mon[5]), .REF_THRESH_SEL(thr_sel), .FIRST_OUT_PECL_ENABLE(drv[8]),
        .FIRST_OUT_PECL_POWER_DOWN(drv[7]), .FIRST_OUT_PECL_SWING(drv[6:5]),
        .FIRST_OUT_PECL_INVERT(drv[4]), .FIRST_OUT_LEG_A_ENABLE(drv[3]),
        .FIRST_OUT_LEG_B_ENABLE(drv[2]), .FIRST_OUT_LEG_A_INVERT(drv[1]),
        .FIRST_OUT_LEG_B_INVERT(drv[0]));

    initial begin
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // expected drive, bus tasks and closing
    // ----------------------------------------------------------------
    function automatic pllsr_pkg::pllsr_drive_t dec(input logic [7:0] v);
        return {~v[7], v[0], v[2:1], v[3], v[7] & v[5], v[7] & v[6], v[3],
            v[7] ? v[4] ^ v[3] : ~v[3]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        tick(12);
        rst = 1'b0;
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
        tick(1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        do_reset();
        `CHK("drive", dec(8'h64), drv)
        `CHK("thr_sel", 1'b0, thr_sel)
        rd_reg(`PLLSR_OFS_OUTPUT0_CTRL, 8'h64);
        rd_reg(`PLLSR_OFS_REF_MONITOR_CFG, 8'h00);
        for (int i = 0; i < 64; i++) begin
            d = {i[4:0], i[2:1], i[5]};
            wr_reg(`PLLSR_OFS_OUTPUT0_CTRL, d);
            `CHK("drive", dec(d), drv)
            rd_reg(`PLLSR_OFS_OUTPUT0_CTRL, d);
        end
        wr_reg(`PLLSR_OFS_REF_MONITOR_CFG, 8'h40);
        `CHK("thr_sel", 1'b1, thr_sel)
        rd_reg(`PLLSR_OFS_REF_MONITOR_CFG, 8'h40);
        wr_reg(`PLLSR_OFS_REF_MONITOR_CFG, 8'hBF);
        `CHK("thr_sel", 1'b0, thr_sel)
        for (int b = 0; b < 8; b++) begin
            mon = (b == 7) ? 7'h7F : 7'h01 << b;
            tick(3);
            rd_reg(`PLLSR_OFS_READBACK_STATUS, {1'b0, mon});
        end
        wr_reg(`PLLSR_OFS_READBACK_STATUS, 8'h00);
        rd_reg(`PLLSR_OFS_READBACK_STATUS, 8'h7F);
        mon = 7'h2A;
        tick(3);
        rd_reg(`PLLSR_OFS_READBACK_STATUS, 8'h2A);
        wr_reg(10'h3FF, 8'h00);
        rd_reg(10'h3FF, 8'h00);
        `CHK("drive", dec(d), drv)
        do_reset();
        `CHK("drive", dec(8'h64), drv)
        report_and_stop();
    end
endmodule
`default_nettype wire
